// *** monitor_host_register_port.sv ***
// host side register port of the hardware monitor
`timescale 1ns/1ps
module monitor_host_register_port
#(
   parameter int SLOT_CYCLES = mon_pkg::SLOT_CYCLES_DEF
)
(
   input wire logic clk_sys,
   input wire logic clk_mon,
   input wire logic reset_n,
   input wire logic chipSelect_n,
   input wire logic ioRead_n,
   input wire logic ioWrite_n,
   input wire logic [2:0] hostAddr,
   input wire logic [7:0] hostDataIn,
   output logic [7:0] hostDataOut,
   output logic hostDataOe,
   input wire logic serialBusy,
   input wire logic serialIndexWe,
   input wire logic serialDataWe,
   input wire logic [7:0] serialWdata,
   output logic [7:0] serialRdata,
   output logic [6:0] serialSlaveAddr,
   input wire logic [7:0] analogResult,
   output logic [3:0] measureSlot,
   input wire logic tachInputOne,
   input wire logic tachInputTwo,
   input wire logic tachInputThree,
   input wire logic boardTempAlertIn_n,
   input wire logic [3:0] voltageIdInputs,
   output logic mgmtInterruptOutLow_n,
   output logic hostInterruptOut,
   output logic powerBypass_n
);
   import mon_pkg::*;

   typedef struct packed {
      logic rdPrev;
      logic wrPrev;
      logic [6:0] index;
      logic [7:0] cfg;
      logic [7:0] stLow;
      logic [7:0] stHigh;
      logic [7:0] mMaskL;
      logic [7:0] mMaskH;
      logic [7:0] hMaskL;
      logic [7:0] hMaskH;
      logic [3:0] fanDiv;
      logic [7:0] serAddr;
      logic [31:0][7:0] postRam;
      logic [4:0] capPtr;
      logic capFull;
      logic [4:0] rwPtr;
      logic [31:0][7:0] vram;
      logic ackTog;
      logic [7:0] dataOut;
      logic dataOe;
      logic [7:0] serRdata;
      logic mgmtOut_n;
      logic hostIrq;
      logic bypass_n;
   } host_state_type;

   localparam host_state_type HOST_RESET = '{
      cfg: RST_CONFIG,
      hMaskH: RST_HOST_MASK_HIGH,
      fanDiv: RST_FAN_DIV,
      serAddr: RST_SERIAL_ADDR,
      mgmtOut_n: 1'b1,
      hostIrq: 1'b1,
      bypass_n: 1'b1,
      default: '0
   };

   host_state_type s_r, s_nxt;
   logic [18:0] pinSync;
   logic csAct, rdAct, wrAct, alertAct, busy;
   logic [2:0] addr;
   logic [7:0] din;
   logic [3:0] voltage_id_inputs;
   logic rdStart, wrStart, dataAcc, capWr, resTogSync, resNew;
   logic resToggle;
   logic [3:0] resSlot;
   logic [7:0] resVal;
   logic mgmtAny, hostAny, hostAct;

   // ==========================================================
   // register read, write and index stepping
   function automatic logic [7:0] regRead(input host_state_type x, input logic [6:0] i,
                                          input logic [3:0] v);
      logic [7:0] r;
      r = 8'h00;
      if (i <= IDX_POST_LAST)
         r = x.postRam[x.rwPtr];
      else if (i[5])
         r = x.vram[i[4:0]];
      else
      begin
         case (i)
            IDX_CONFIG: r = x.cfg;
            IDX_STATUS_LOW: r = x.stLow;
            IDX_STATUS_HIGH: r = x.stHigh;
            IDX_MGMT_MASK_LOW: r = x.mMaskL;
            IDX_MGMT_MASK_HIGH: r = x.mMaskH;
            IDX_HOST_MASK_LOW: r = x.hMaskL;
            IDX_HOST_MASK_HIGH: r = x.hMaskH;
            IDX_FAN_VID: r = {x.fanDiv, v};
            IDX_SERIAL_ADDR: r = x.serAddr;
            default: r = 8'h00;
         endcase
      end
      return r;
   endfunction

   function automatic host_state_type regWrite(input host_state_type x, input logic [6:0] i,
                                               input logic [7:0] d);
      host_state_type y;
      y = x;
      if (i <= IDX_POST_LAST)
         y.postRam[x.rwPtr] = d;
      else if (i[5])
         y.vram[i[4:0]] = d;
      else
      begin
         case (i)
            IDX_CONFIG:
               if (d[CFG_INIT])
               begin
                  // init reloads everything but the serial address and rams
                  y.cfg = RST_CONFIG;
                  y.stLow = 8'h00;
                  y.stHigh = 8'h00;
                  y.mMaskL = 8'h00;
                  y.mMaskH = 8'h00;
                  y.hMaskL = 8'h00;
                  y.hMaskH = RST_HOST_MASK_HIGH;
                  y.fanDiv = RST_FAN_DIV;
               end
               else
                  y.cfg = d;
            IDX_MGMT_MASK_LOW: y.mMaskL = d;
            IDX_MGMT_MASK_HIGH: y.mMaskH = d;
            IDX_HOST_MASK_LOW: y.hMaskL = d;
            IDX_HOST_MASK_HIGH: y.hMaskH = d;
            IDX_FAN_VID: y.fanDiv = d[7:4];
            IDX_SERIAL_ADDR: y.serAddr = d;
            default: y.cfg = x.cfg;
         endcase
      end
      return y;
   endfunction

   function automatic logic [6:0] nextIndex(input logic [6:0] i);
      if (i == IDX_STATUS_LOW || i == IDX_MGMT_MASK_LOW || i == IDX_HOST_MASK_LOW)
         return i + 7'h1;
      else if (i[6:5] == 2'b11 && i != IDX_MIRROR_LAST)
         return i + 7'h1;
      else
         return i;
   endfunction

   function automatic logic violates(input logic [3:0] k, input logic [7:0] v,
                                     input logic [31:0][7:0] m);
      logic [4:0] hi;
      hi = LIM_IN_HIGH + {k - 4'h1, 1'b0};
      if (k == 4'h0)
         return $signed(v) > $signed(m[LIM_TEMP]);
      else if (k >= SLOT_FAN_FIRST)
         return v > m[LIM_FAN + {1'b0, k - SLOT_FAN_FIRST}];
      else
         return (v > m[hi]) || (v < m[hi + 5'h1]);
   endfunction

   // ==========================================================
   // pin synchronisers and the monitor clock domain
   sync_two_stage #(.W(19), .RESET_VAL(RST_PIN_SYNC)) u_pinSync (
      .clk(clk_sys),
      .reset_n(reset_n),
      .d({chipSelect_n, ioRead_n, ioWrite_n, hostAddr, hostDataIn,
          boardTempAlertIn_n, voltageIdInputs}),
      .q(pinSync)
   );

   sync_two_stage #(.W(1)) u_resSync (
      .clk(clk_sys),
      .reset_n(reset_n),
      .d(resToggle),
      .q(resTogSync)
   );

   // conversion timing stays on the internal clock
   monitor_engine #(.SLOT_CYCLES(SLOT_CYCLES)) u_engine (
      .clk_mon(clk_mon),
      .reset_n(reset_n),
      .startLevel(s_r.cfg[CFG_START] & ~s_r.cfg[CFG_INT_CLEAR]),
      .ackToggle(s_r.ackTog),
      .fanDivisors(s_r.fanDiv),
      .analogResult(analogResult),
      .tachInputs({tachInputThree, tachInputTwo, tachInputOne}),
      .measureSlot(measureSlot),
      .resultToggle(resToggle),
      .resultSlot(resSlot),
      .resultValue(resVal)
   );

   assign csAct = ~pinSync[18];
   assign rdAct = csAct & ~pinSync[17];
   assign wrAct = csAct & ~pinSync[16];
   assign addr = pinSync[15:13];
   assign din = pinSync[12:5];
   assign alertAct = ~pinSync[4];
   assign voltage_id_inputs = pinSync[3:0];
   assign busy = serialBusy;
   assign rdStart = rdAct & ~s_r.rdPrev;
   assign wrStart = wrAct & ~s_r.wrPrev;
   assign dataAcc = (rdStart | wrStart) & (addr == PORT_DATA) & ~busy;
   assign capWr = wrStart & (addr == PORT_POST_A || addr == PORT_POST_B);
   assign resNew = resTogSync != s_r.ackTog;
   assign mgmtAny = |((s_r.stLow & ~s_r.mMaskL) | (s_r.stHigh & ~s_r.mMaskH));
   assign hostAny = |((s_r.stLow & ~s_r.hMaskL) | (s_r.stHigh & ~s_r.hMaskH));
   assign hostAct = s_r.cfg[CFG_HOST_EN] & ~s_r.cfg[CFG_INT_CLEAR] & hostAny;

   // ==========================================================
   // host port, serial access, results and interrupt outputs
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rdPrev = rdAct;
      s_nxt.wrPrev = wrAct;
      s_nxt.dataOe = rdAct;
      if (rdStart)
      begin
         if (addr == PORT_INDEX)
            s_nxt.dataOut = {busy, s_r.index};
         else if (dataAcc)
            s_nxt.dataOut = regRead(s_r, s_r.index, voltage_id_inputs);
         else
            s_nxt.dataOut = 8'h00;
      end
      if (wrStart && addr == PORT_INDEX && !busy)
      begin
         s_nxt.index = din[6:0];
         if (din[6:5] == 2'b00)
            s_nxt.rwPtr = din[4:0];
      end
      if (wrStart && dataAcc)
         s_nxt = regWrite(s_nxt, s_r.index, din);
      if (dataAcc)
      begin
         s_nxt.index = nextIndex(s_r.index);
         if (s_r.index <= IDX_POST_LAST && s_r.rwPtr != PTR_LAST)
            s_nxt.rwPtr = s_r.rwPtr + 5'h1;
         if (rdStart && s_r.index == IDX_STATUS_LOW)
            s_nxt.stLow = 8'h00;
         if (rdStart && s_r.index == IDX_STATUS_HIGH)
            s_nxt.stHigh = 8'h00;
      end
      // serial slave: same registers, never auto-increments
      if (serialIndexWe)
      begin
         s_nxt.index = serialWdata[6:0];
         if (serialWdata[6:5] == 2'b00)
            s_nxt.rwPtr = serialWdata[4:0];
      end
      if (serialDataWe)
         s_nxt = regWrite(s_nxt, s_r.index, serialWdata);
      s_nxt.serRdata = regRead(s_r, s_r.index, voltage_id_inputs);
      if (capWr)
      begin
         if (s_r.capFull)
            s_nxt.stHigh[ST_POST_OVF] = 1'b1;
         else
         begin
            s_nxt.postRam[s_r.capPtr] = din;
            if (s_r.capPtr == PTR_LAST)
               s_nxt.capFull = 1'b1;
            else
               s_nxt.capPtr = s_r.capPtr + 5'h1;
         end
      end
      // event sets come last so they win over a clear
      if (resNew)
      begin
         s_nxt.ackTog = resTogSync;
         s_nxt.vram[{1'b0, resSlot}] = resVal;
         if (violates(resSlot, resVal, s_r.vram))
         begin
            if (resSlot < SLOT_FAN_FIRST)
               s_nxt.stLow[resSlot[2:0]] = 1'b1;
            else
               s_nxt.stHigh[resSlot[2:0]] = 1'b1;
         end
      end
      if (alertAct)
         s_nxt.stHigh[ST_ALERT] = 1'b1;
      s_nxt.mgmtOut_n = ~(s_r.cfg[CFG_MGMT_EN] & ~s_r.cfg[CFG_INT_CLEAR] & mgmtAny);
      s_nxt.hostIrq = s_r.cfg[CFG_HOST_POL] ? hostAct : ~hostAct;
      s_nxt.bypass_n = ~s_r.cfg[CFG_BYPASS];
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         s_r <= HOST_RESET;
      else
         s_r <= s_nxt;
   end

   assign hostDataOut = s_r.dataOut;
   assign hostDataOe = s_r.dataOe;
   assign serialRdata = s_r.serRdata;
   assign serialSlaveAddr = s_r.serAddr[6:0];
   assign mgmtInterruptOutLow_n = s_r.mgmtOut_n;
   assign hostInterruptOut = s_r.hostIrq;
   assign powerBypass_n = s_r.bypass_n;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   pair_step_a: assert property (
      dataAcc && !serialIndexWe && s_r.index == IDX_HOST_MASK_LOW
      |=> s_r.index == IDX_HOST_MASK_HIGH)
      else $error("pair index did not advance");
   mirror_stop_a: assert property (
      dataAcc && !serialIndexWe && s_r.index == IDX_MIRROR_LAST |=> s_r.index == IDX_MIRROR_LAST)
      else $error("mirror index moved past the end");
   serial_noinc_a: assert property (
      serialDataWe && !dataAcc && !serialIndexWe && !wrStart |=> $stable(s_r.index))
      else $error("serial access changed the index");
   capture_step_a: assert property (
      capWr && !s_r.capFull && s_r.capPtr != PTR_LAST |=> s_r.capPtr == $past(s_r.capPtr) + 5'h1)
      else $error("capture pointer did not advance");
   capture_ovf_a: assert property (
      capWr && s_r.capFull |=> s_r.stHigh[ST_POST_OVF] ##1 s_r.stHigh[ST_POST_OVF] || dataAcc)
      else $error("capture overflow not flagged");
   capture_read_a: assert property (
      rdStart && (addr == PORT_POST_A || addr == PORT_POST_B) && !capWr
      |=> $stable(s_r.capPtr) && !$rose(s_r.stHigh[ST_POST_OVF]))
      else $error("capture port read disturbed state");
   busy_read_a: assert property (
      rdStart && addr == PORT_INDEX |=> hostDataOut[7] == $past(busy) && hostDataOe)
      else $error("busy bit wrong on index read");
   init_clear_a: assert property (
      wrStart && dataAcc && s_r.index == IDX_CONFIG && din[CFG_INIT] && !serialDataWe
      |=> s_r.cfg == RST_CONFIG ##1 !s_r.cfg[CFG_INIT] || dataAcc || serialDataWe)
      else $error("init did not reload configuration");
   mgmt_gate_a: assert property (
      !s_r.cfg[CFG_MGMT_EN] [*2] |-> mgmtInterruptOutLow_n)
      else $error("management interrupt active while disabled");
endmodule

// *** mon_pkg.sv ***
// shared constants for the monitor host register port
package mon_pkg;
   // host port offsets, low three address bits
   localparam logic [2:0] PORT_POST_A = 3'h0;
   localparam logic [2:0] PORT_POST_B = 3'h4;
   localparam logic [2:0] PORT_INDEX = 3'h5;
   localparam logic [2:0] PORT_DATA = 3'h6;
   // internal register indexes
   localparam logic [6:0] IDX_POST_LAST = 7'h1f;
   localparam logic [6:0] IDX_CONFIG = 7'h40;
   localparam logic [6:0] IDX_STATUS_LOW = 7'h41;
   localparam logic [6:0] IDX_STATUS_HIGH = 7'h42;
   localparam logic [6:0] IDX_MGMT_MASK_LOW = 7'h43;
   localparam logic [6:0] IDX_MGMT_MASK_HIGH = 7'h44;
   localparam logic [6:0] IDX_HOST_MASK_LOW = 7'h45;
   localparam logic [6:0] IDX_HOST_MASK_HIGH = 7'h46;
   localparam logic [6:0] IDX_FAN_VID = 7'h47;
   localparam logic [6:0] IDX_SERIAL_ADDR = 7'h48;
   localparam logic [6:0] IDX_MIRROR_LAST = 7'h7f;
   localparam logic [4:0] PTR_LAST = 5'h1f;
   // values after reset
   localparam logic [7:0] RST_CONFIG = 8'h08;
   localparam logic [7:0] RST_HOST_MASK_HIGH = 8'h40;
   localparam logic [3:0] RST_FAN_DIV = 4'h5;
   localparam logic [7:0] RST_SERIAL_ADDR = 8'h2d;
   localparam logic [18:0] RST_PIN_SYNC = 19'h70010;
   // configuration bit positions
   localparam int CFG_START = 0;
   localparam int CFG_MGMT_EN = 1;
   localparam int CFG_HOST_EN = 2;
   localparam int CFG_INT_CLEAR = 3;
   localparam int CFG_HOST_POL = 5;
   localparam int CFG_BYPASS = 6;
   localparam int CFG_INIT = 7;
   // high status bits beyond the fan slots
   localparam int ST_ALERT = 3;
   localparam int ST_POST_OVF = 4;
   // limit locations, offsets within the value ram
   localparam logic [4:0] LIM_IN_HIGH = 5'h0b;
   localparam logic [4:0] LIM_TEMP = 5'h19;
   localparam logic [4:0] LIM_FAN = 5'h1b;
   // measurement sequence
   localparam logic [3:0] SLOT_FAN_FIRST = 4'h8;
   localparam logic [3:0] SLOT_LAST = 4'ha;
   localparam logic [1:0] TACH_INPUT_THREE_DIV_CODE = 2'h1;
   // monitor timing
   localparam int MON_CLK_NS = 160;
   localparam int SLOT_TIME_US = 90909;
   localparam int SLOT_CYCLES_DEF = SLOT_TIME_US * 1000 / MON_CLK_NS;
   localparam int FAN_TICK_NS = 22300;
   localparam int FAN_TICK_CYCLES = (FAN_TICK_NS + MON_CLK_NS - 1) / MON_CLK_NS;
endpackage

// *** sync_two_stage.sv ***
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
module sync_two_stage
#(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r <= RESET_VAL;
         q <= RESET_VAL;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// *** monitor_engine.sv ***
// round-robin measurement sequencer on the internal monitor clock
`timescale 1ns/1ps
module monitor_engine
#(
   parameter int SLOT_CYCLES = mon_pkg::SLOT_CYCLES_DEF
)
(
   input wire logic clk_mon,
   input wire logic reset_n,
   input wire logic startLevel,
   input wire logic ackToggle,
   input wire logic [3:0] fanDivisors,
   input wire logic [7:0] analogResult,
   input wire logic [2:0] tachInputs,
   output logic [3:0] measureSlot,
   output logic resultToggle,
   output logic [3:0] resultSlot,
   output logic [7:0] resultValue
);
   import mon_pkg::*;

   typedef struct packed {
      logic [3:0] slot;
      logic [19:0] timer;
      logic [10:0] prescale;
      logic [7:0] fanCount;
      logic tachPrev;
      logic seen;
      logic done;
      logic reqTog;
      logic [3:0] resSlot;
      logic [7:0] resVal;
   } eng_state_type;

   eng_state_type s_r, s_nxt;
   logic [8:0] syncOut;
   logic startSync, ackSync, fanSlot, tachNow, rise;
   logic [1:0] sel, divCode;
   logic [10:0] tickLast;

   sync_two_stage #(.W(9)) u_sync (
      .clk(clk_mon),
      .reset_n(reset_n),
      .d({startLevel, ackToggle, fanDivisors, tachInputs}),
      .q(syncOut)
   );

   assign startSync = syncOut[8];
   assign ackSync = syncOut[7];
   assign fanSlot = s_r.slot >= SLOT_FAN_FIRST;
   assign sel = s_r.slot[1:0];
   assign tachNow = syncOut[sel];
   assign divCode = (sel == 2'h0) ? syncOut[4:3] : (sel == 2'h1) ? syncOut[6:5] : TACH_INPUT_THREE_DIV_CODE;
   assign tickLast = (11'(FAN_TICK_CYCLES) << divCode) - 11'h1;
   assign rise = tachNow & ~s_r.tachPrev;

   // ==========================================================
   // sequencing and fan period counting
   always_comb
   begin
      s_nxt = s_r;
      if (!startSync)
      begin
         s_nxt.slot = 4'h0;
         s_nxt.timer = 20'h0;
         s_nxt.seen = 1'b0;
         s_nxt.done = 1'b0;
         s_nxt.tachPrev = 1'b1;
      end
      else
      begin
         s_nxt.tachPrev = tachNow;
         if (fanSlot)
         begin
            s_nxt.prescale = (s_r.prescale == tickLast) ? 11'h0 : s_r.prescale + 11'h1;
            if (rise && !s_r.seen)
            begin
               s_nxt.seen = 1'b1;
               s_nxt.prescale = 11'h0;
               s_nxt.fanCount = 8'h00;
            end
            else if (rise && s_r.seen)
               s_nxt.done = 1'b1;
            else if (s_r.seen && !s_r.done && s_r.prescale == tickLast && s_r.fanCount != 8'hff)
               s_nxt.fanCount = s_r.fanCount + 8'h01;
         end
         if (s_r.timer == 20'(SLOT_CYCLES - 1))
         begin
            s_nxt.timer = 20'h0;
            s_nxt.slot = (s_r.slot == SLOT_LAST) ? 4'h0 : s_r.slot + 4'h1;
            s_nxt.seen = 1'b0;
            s_nxt.done = 1'b0;
            s_nxt.prescale = 11'h0;
            s_nxt.tachPrev = 1'b1;
            if (s_r.reqTog == ackSync)
            begin
               s_nxt.reqTog = ~s_r.reqTog;
               s_nxt.resSlot = s_r.slot;
               // no second edge inside the slot reads as stopped
               s_nxt.resVal = fanSlot ? (s_r.done ? s_r.fanCount : 8'hff) : analogResult;
            end
         end
         else
            s_nxt.timer = s_r.timer + 20'h1;
      end
   end

   always_ff @(posedge clk_mon or negedge reset_n)
   begin
      if (!reset_n)
         s_r <= '{tachPrev: 1'b1, default: '0};
      else
         s_r <= s_nxt;
   end

   assign measureSlot = s_r.slot;
   assign resultToggle = s_r.reqTog;
   assign resultSlot = s_r.resSlot;
   assign resultValue = s_r.resVal;
endmodule

// *** host_bus_model.sv ***
// host processor model driving the parallel register port
`timescale 1ns/1ps
module host_bus_model
(
   input wire logic clk,
   input wire logic [7:0] hostDataOut,
   output logic chipSelect_n,
   output logic ioRead_n,
   output logic ioWrite_n,
   output logic [2:0] hostAddr,
   output logic [7:0] hostDataIn
);
   initial
   begin
      chipSelect_n = 1'b1;
      ioRead_n = 1'b1;
      ioWrite_n = 1'b1;
      hostAddr = 3'h7;
      hostDataIn = 8'h00;
   end
   // ==========================================
   // one strobed transfer, held past the answer
   task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk);
      hostAddr <= a;
      hostDataIn <= d;
      chipSelect_n <= 1'b0;
      if (wr)
      begin
         ioWrite_n <= 1'b0;
      end
      else
      begin
         ioRead_n <= 1'b0;
      end
      repeat (6) @(posedge clk);
      q = hostDataOut;
      chipSelect_n <= 1'b1;
      ioRead_n <= 1'b1;
      ioWrite_n <= 1'b1;
      hostDataIn <= ~d;
      hostAddr <= ~a;
      repeat (3) @(posedge clk);
   endtask
endmodule

// *** monitor_host_register_port_tb.sv ***
// self-checking bench for the monitor host register port
`timescale 1ns/1ps
module monitor_host_register_port_tb;
   import mon_pkg::*;
   logic clk_sys = 1'b0;
   logic clk_mon = 1'b0;
   logic reset_n = 1'b0;
   logic chipSelect_n, ioRead_n, ioWrite_n;
   logic [2:0] hostAddr;
   logic [7:0] hostDataIn, hostDataOut, q, serialRdata;
   logic serialBusy = 1'b0;
   logic serialIndexWe = 1'b0;
   logic serialDataWe = 1'b0;
   logic [7:0] serialWdata = 8'h00;
   logic [6:0] serialSlaveAddr;
   logic alert_n = 1'b1;
   logic [3:0] voltage_id_inputs = 4'ha;
   logic mgmtIrq_n, hostIrq;
   int nErrors = 0;
   int checkCount = 0;
   always #50 clk_sys = ~clk_sys;
   always #80 clk_mon = ~clk_mon;
   host_bus_model hb (.clk(clk_sys), .hostDataOut(hostDataOut), .chipSelect_n(chipSelect_n),
      .ioRead_n(ioRead_n), .ioWrite_n(ioWrite_n), .hostAddr(hostAddr), .hostDataIn(hostDataIn));
   monitor_host_register_port #(.SLOT_CYCLES(40)) uut (.clk_sys(clk_sys), .clk_mon(clk_mon),
      .reset_n(reset_n), .chipSelect_n(chipSelect_n), .ioRead_n(ioRead_n),
      .ioWrite_n(ioWrite_n), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
      .hostDataOut(hostDataOut), .hostDataOe(), .serialBusy(serialBusy),
      .serialIndexWe(serialIndexWe), .serialDataWe(serialDataWe), .serialWdata(serialWdata),
      .serialRdata(serialRdata), .serialSlaveAddr(serialSlaveAddr), .analogResult(8'h00),
      .measureSlot(), .tachInputOne(1'b0), .tachInputTwo(1'b0), .tachInputThree(1'b0),
      .boardTempAlertIn_n(alert_n), .voltageIdInputs(voltage_id_inputs), .mgmtInterruptOutLow_n(mgmtIrq_n),
      .hostInterruptOut(hostIrq), .powerBypass_n());
   // ==========================================
   // compare, access and closing tasks
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      checkCount++;
      if (g !== e)
      begin
         nErrors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      hb.xfer(1'b1, a, d, q);
   endtask
   task automatic rdChk(input logic [2:0] a, input logic [7:0] e, input string what);
      hb.xfer(1'b0, a, 8'h00, q);
      chk(what, e, q);
   endtask
   task automatic regChk(input logic [6:0] i, input logic [7:0] e, input string what);
      wr(PORT_INDEX, {1'b0, i});
      rdChk(PORT_DATA, e, what);
   endtask
   task automatic closeOut;
      if (nErrors == 0 && checkCount > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      nErrors++;
      closeOut();
   end
   // ==========================================
   // test sequence
   initial
   begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      regChk(IDX_CONFIG, RST_CONFIG, "config");
      regChk(IDX_STATUS_LOW, 8'h00, "status low");
      rdChk(PORT_INDEX, {1'b0, IDX_STATUS_HIGH}, "index pair");
      regChk(IDX_MGMT_MASK_LOW, 8'h00, "mgmt mask low");
      rdChk(PORT_DATA, 8'h00, "mgmt mask high");
      regChk(IDX_HOST_MASK_LOW, 8'h00, "host mask low");
      rdChk(PORT_DATA, RST_HOST_MASK_HIGH, "host mask high");
      regChk(IDX_FAN_VID, {RST_FAN_DIV, 4'ha}, "fan vid");
      regChk(IDX_SERIAL_ADDR, RST_SERIAL_ADDR, "serial addr");
      for (int i = 0; i < 33; i++)
      begin
         wr(i[0] ? PORT_POST_B : PORT_POST_A, 8'h80 + 8'(i));
      end
      rdChk(PORT_POST_A, 8'h00, "capture read");
      regChk(IDX_STATUS_HIGH, 8'h10, "overflow");
      wr(PORT_INDEX, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         rdChk(PORT_DATA, 8'h80 + 8'(i), "boot ram");
      end
      wr(PORT_INDEX, 8'h7e);
      wr(PORT_DATA, 8'h11);
      wr(PORT_DATA, 8'h22);
      wr(PORT_DATA, 8'h33);
      rdChk(PORT_INDEX, 8'h7f, "mirror stop");
      regChk(7'h3e, 8'h11, "mirror alias");
      rdChk(PORT_INDEX, 8'h3e, "index kept");
      regChk(7'h3f, 8'h33, "mirror last");
      @(posedge clk_sys);
      serialIndexWe <= 1'b1;
      serialWdata <= {1'b0, IDX_SERIAL_ADDR};
      @(posedge clk_sys);
      serialIndexWe <= 1'b0;
      serialDataWe <= 1'b1;
      serialWdata <= 8'h55;
      @(posedge clk_sys);
      serialDataWe <= 1'b0;
      serialBusy <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("serial addr out", 8'h55, {1'b0, serialSlaveAddr});
      chk("serial rdata", 8'h55, serialRdata);
      rdChk(PORT_INDEX, 8'hc8, "busy bit");
      wr(PORT_DATA, 8'h66);
      serialBusy <= 1'b0;
      rdChk(PORT_DATA, 8'h55, "busy lockout");
      wr(PORT_DATA, 8'h2a);
      chk("host addr write", 8'h2a, {1'b0, serialSlaveAddr});
      regChk(IDX_MGMT_MASK_LOW, 8'h00, "mask before init");
      wr(PORT_INDEX, {1'b0, IDX_MGMT_MASK_LOW});
      wr(PORT_DATA, 8'hff);
      wr(PORT_INDEX, {1'b0, IDX_CONFIG});
      wr(PORT_DATA, 8'h80);
      rdChk(PORT_DATA, RST_CONFIG, "init clears");
      regChk(IDX_MGMT_MASK_LOW, 8'h00, "init mask");
      wr(PORT_INDEX, {1'b0, IDX_CONFIG});
      wr(PORT_DATA, 8'h02);
      alert_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      chk("mgmt irq", 8'h00, {7'h0, mgmtIrq_n});
      wr(PORT_INDEX, {1'b0, IDX_MGMT_MASK_HIGH});
      wr(PORT_DATA, 8'h08);
      repeat (10) @(posedge clk_sys);
      chk("mgmt irq masked", 8'h01, {7'h0, mgmtIrq_n});
      wr(PORT_INDEX, {1'b0, IDX_CONFIG});
      wr(PORT_DATA, 8'h04);
      chk("host irq low", 8'h00, {7'h0, hostIrq});
      wr(PORT_DATA, 8'h24);
      chk("host irq high", 8'h01, {7'h0, hostIrq});
      alert_n <= 1'b1;
      regChk(IDX_STATUS_HIGH, 8'h08, "alert status");
      wr(PORT_INDEX, {1'b0, IDX_CONFIG});
      wr(PORT_DATA, 8'h01);
      // one full round of eleven slots at forty monitor cycles each
      repeat (850) @(posedge clk_sys);
      regChk(7'h28, 8'hff, "fan count");
      regChk(IDX_STATUS_HIGH, 8'h07, "fan status");
      closeOut();
   end
endmodule
